// ---- pkg/phy_dsp_diag_pkg.sv ----
// Package of register offsets, reset values, field positions and
// encodings for the receive DSP and cable diagnostic register bank.
// Assumes a 16-bit register port with a 9-bit word address.
`default_nettype none
package phy_dsp_diag_pkg;
   // ----------------------------------------------------------------
   // Bus widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 9;
   localparam int DATA_W = 16;
   localparam int GAIN_W = 4;
   localparam int MSE_W = 15;
   localparam int SUM_W = 8;
   localparam int AVG_W = 7;

   // ----------------------------------------------------------------
   // Plain storage registers, by index
   // ----------------------------------------------------------------
   localparam int NUM_STORE = 11;
   localparam int IDX_DSP3 = 0;
   localparam int IDX_DFE = 1;
   localparam int IDX_AGC = 2;
   localparam int IDX_RECOV = 3;
   localparam int IDX_TLOOP = 4;
   localparam int IDX_LINKUP = 5;
   localparam int IDX_TIMERS = 6;
   localparam int IDX_GLIM = 7;
   localparam int IDX_RETRAIN = 8;
   localparam int IDX_REFL = 9;
   localparam int IDX_PULSE = 10;

   localparam logic [ADDR_W-1:0] STORE_OFFSET [NUM_STORE] = '{
      9'h111, 9'h114, 9'h116, 9'h121, 9'h122, 9'h123,
      9'h126, 9'h129, 9'h130, 9'h170, 9'h171};
   localparam logic [DATA_W-1:0] STORE_RESET [NUM_STORE] = '{
      16'h6003, 16'h400A, 16'h014A, 16'h199A, 16'h1027, 16'h051C,
      16'h461B, 16'h000F, 16'h0001, 16'h0E52, 16'hC85C};
   localparam logic [DATA_W-1:0] STORE_WMASK [NUM_STORE] = '{
      16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h7FFF, 16'h7FFF, 16'h7FFF,
      16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h7FFF, 16'hFFFF};

   // ----------------------------------------------------------------
   // Special registers
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ALT_OFFSET = 9'h155;
   localparam logic [ADDR_W-1:0] INT_STATUS_OFFSET = 9'h1F0;
   localparam logic [ADDR_W-1:0] INT_MASK_OFFSET = 9'h1F1;
   localparam logic [3:0] ALT_LOW_RESET = 4'h1;
   localparam int ALT_START_BIT = 15;
   localparam int ALT_BUSY_BIT = 12;
   localparam int ALT_SUM_LSB = 4;
   localparam int ALT_LOW_MSB = 3;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int START_GAIN_LSB = 0;
   localparam int MAX_GAIN_LSB = 4;
   localparam int MIN_GAIN_LSB = 0;
   localparam int RETRAIN_DIS_BIT = 11;
   localparam int CROSS_DIS_BIT = 14;
   localparam int TX_BYPASS_BIT = 13;
   localparam int RX_BYPASS_BIT = 12;
   localparam int AVG_LSB = 8;
   localparam int AVG_CODE_W = 3;
   localparam int PULSE_LSB = 0;
   localparam int PULSE_W = 4;
   localparam int TMR_SHIFT_LSB = 12;
   localparam int TMR_SHIFT_W = 3;
   localparam int TMR_TLOOP_LSB = 6;
   localparam int TMR_TLOOP_W = 6;
   localparam int TMR_GAIN_A_LSB = 3;
   localparam int TMR_GAIN_B_LSB = 0;
   localparam int TMR_GAIN_W = 3;

   localparam logic [AVG_CODE_W-1:0] AVG_RESERVED = 3'h7;
   localparam logic [AVG_W-1:0] AVG_ONE = 7'h01;
   localparam logic [AVG_W-1:0] AVG_RESERVED_COUNT = 7'h40;

   // ----------------------------------------------------------------
   // Interrupt bits
   // ----------------------------------------------------------------
   localparam int NUM_IRQ = 3;
   localparam int IRQ_ALT_DONE = 0;
   localparam int IRQ_REFL_DONE = 1;
   localparam int IRQ_RECOVERY = 2;
endpackage
`default_nettype wire

// ---- rtl/gain_index_clamp.sv ----
// Gain index selector that clamps the training gain, checking the maximum limit before the minimum.
// Assumes limits and requests are synchronous to clock.
`default_nettype none
module gain_index_clamp
   import phy_dsp_diag_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Limits and requests
   input wire logic [GAIN_W-1:0] start_index,
   input wire logic [GAIN_W-1:0] max_index,
   input wire logic [GAIN_W-1:0] min_index,
   input wire logic [GAIN_W-1:0] req_index,
   input wire logic training_start,
   // Selected gain index
   output logic [GAIN_W-1:0] gain_index
);
   logic [GAIN_W-1:0] gain_index_reg;
   logic [GAIN_W-1:0] raw_index;
   logic [GAIN_W-1:0] gain_index_next;

   // ----------------------------------------------------------------
   // Selection
   // ----------------------------------------------------------------
   assign raw_index = training_start ? start_index : req_index;
   assign gain_index_next = (raw_index > max_index) ? max_index :
                            (raw_index < min_index) ? min_index :
                            raw_index;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         gain_index_reg <= '0;
      end else begin
         gain_index_reg <= gain_index_next;
      end
   end

   assign gain_index = gain_index_reg;
endmodule
`default_nettype wire

// ---- rtl/mse_threshold_compare.sv ----
// Mean-square error comparator for the 100M receive DSP.
// Assumes the error sample is synchronous to clock.
`default_nettype none
module mse_threshold_compare
   import phy_dsp_diag_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Error and thresholds
   input wire logic speed_100,
   input wire logic [MSE_W-1:0] mse_value,
   input wire logic [MSE_W-1:0] bad_threshold,
   input wire logic [MSE_W-1:0] good1_threshold,
   input wire logic [MSE_W-1:0] good2_threshold,
   // Decisions
   output logic recovery_enter,
   output logic timing_converged,
   output logic linkup_ok
);
   logic recovery_reg;
   logic converged_reg;
   logic linkup_reg;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         recovery_reg <= 1'b0;
         converged_reg <= 1'b0;
         linkup_reg <= 1'b0;
      end else begin
         recovery_reg <= speed_100 && (mse_value > bad_threshold);
         converged_reg <= speed_100 && (mse_value < good1_threshold);
         linkup_reg <= speed_100 && (mse_value < good2_threshold);
      end
   end

   assign recovery_enter = recovery_reg;
   assign timing_converged = converged_reg;
   assign linkup_ok = linkup_reg;
endmodule
`default_nettype wire

// ---- rtl/phy_dsp_cable_diag_regs.sv ----
// Register bank for the 100M receive DSP and the cable diagnostic engine.
// Assumes a one-cycle register port synchronous to clock and engines that
// report completion with one-cycle pulses.
//
// Functional notes
// - Writing one to start bit launches the active-link test; bit self-clears.
// - Status bit reads one while the active-link test runs, zero when done.
// - Cross-disable zero makes reflectometry also watch the other pair.
// - Transmit-pair bypass one skips reflectometry on the transmit pair.
// - Receive-pair bypass one skips reflectometry on the receive pair.
// - Averaging code n gives two to the n cycles; code seven reserved.
// - Pulse field sets expected self-reflection level, default 1100.
// - Retrain disable one blocks receive gain retraining.
// - Gain training selects above the maximum field only when the minimum field exceeds it.
// - Gain training selects below the minimum field only when that field exceeds the maximum.
// - Gain training starts from the starting gain index field.
// - Error above bad threshold moves the 100M DSP into recovery.
// - Timing loop convergence judged against the first good threshold.
// - Link-up permission judged against the second good threshold.
// - Four timer fields govern state shift, timing loop and gain loop.
//
// Our own choice: strobed register access.
`default_nettype none
module phy_dsp_cable_diag_regs
   import phy_dsp_diag_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [DATA_W-1:0] rdata,
   // Interrupt
   output logic irq,
   // Gain training
   input wire logic [GAIN_W-1:0] gain_req_index,
   input wire logic gain_training_start,
   input wire logic gain_retrain_req,
   output logic [GAIN_W-1:0] gain_index,
   output logic gain_retrain_allow,
   // Error monitor
   input wire logic speed_100,
   input wire logic [MSE_W-1:0] mse_value,
   output logic recovery_enter,
   output logic timing_converged,
   output logic linkup_ok,
   // Training timers
   output logic [TMR_SHIFT_W-1:0] timer_state_shift,
   output logic [TMR_TLOOP_W-1:0] timer_timing_loop,
   output logic [TMR_GAIN_W-1:0] timer_gain_a,
   output logic [TMR_GAIN_W-1:0] timer_gain_b,
   // Active-link cable test
   output logic active_link_cable_test_start,
   input wire logic active_link_test_done,
   input wire logic [SUM_W-1:0] active_link_test_sum,
   // Reflectometry
   output logic reflect_cross_enable,
   output logic reflect_run_transmit_pair,
   output logic reflect_run_receive_pair,
   output logic [AVG_W-1:0] reflect_average_count,
   output logic [PULSE_W-1:0] reflect_pulse_level,
   input wire logic reflect_done
);
   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   function automatic logic [NUM_STORE-1:0] store_hit(input logic [ADDR_W-1:0] a);
      logic [NUM_STORE-1:0] hit;
      hit = '0;
      for (int k = 0; k < NUM_STORE; k++) begin
         hit[k] = (a == STORE_OFFSET[k]);
      end
      return hit;
   endfunction

   logic [DATA_W-1:0] store_reg [NUM_STORE];
   logic [NUM_STORE-1:0] wr_sel;
   logic [NUM_STORE-1:0] rd_sel;
   logic wr_alt;
   logic wr_int_status;
   logic wr_int_mask;
   logic rd_alt;
   logic rd_int_status;
   logic rd_int_mask;

   assign wr_sel = wr ? store_hit(addr) : '0;
   assign rd_sel = store_hit(addr);
   assign wr_alt = wr && (addr == ALT_OFFSET);
   assign wr_int_status = wr && (addr == INT_STATUS_OFFSET);
   assign wr_int_mask = wr && (addr == INT_MASK_OFFSET);
   assign rd_alt = (addr == ALT_OFFSET);
   assign rd_int_status = (addr == INT_STATUS_OFFSET);
   assign rd_int_mask = (addr == INT_MASK_OFFSET);

   // ----------------------------------------------------------------
   // Storage registers
   // ----------------------------------------------------------------
   generate
      for (genvar i = 0; i < NUM_STORE; i++) begin : g_store
         always_ff @(posedge clock) begin
            if (!rstn) begin
               store_reg[i] <= STORE_RESET[i];
            end else if (wr_sel[i]) begin
               store_reg[i] <= wdata & STORE_WMASK[i];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Active-link cable test
   // ----------------------------------------------------------------
   logic alt_start_reg;
   logic alt_busy_reg;
   logic alt_busy_next;
   logic [SUM_W-1:0] alt_sum_reg;
   logic [ALT_LOW_MSB:0] alt_low_reg;
   logic alt_launch;

   assign alt_launch = wr_alt && wdata[ALT_START_BIT];
   assign alt_busy_next = alt_launch ? 1'b1 :
                          active_link_test_done ? 1'b0 : alt_busy_reg;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         alt_start_reg <= 1'b0;
         alt_busy_reg <= 1'b0;
         alt_sum_reg <= '0;
         alt_low_reg <= ALT_LOW_RESET;
      end else begin
         alt_start_reg <= alt_launch;
         alt_busy_reg <= alt_busy_next;
         if (active_link_test_done && alt_busy_reg) begin
            alt_sum_reg <= active_link_test_sum;
         end
         if (wr_alt) begin
            alt_low_reg <= wdata[ALT_LOW_MSB:0];
         end
      end
   end

   assign active_link_cable_test_start = alt_start_reg;

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   logic [NUM_IRQ-1:0] int_status_reg;
   logic [NUM_IRQ-1:0] int_mask_reg;
   logic [NUM_IRQ-1:0] int_event;
   logic [NUM_IRQ-1:0] int_status_next;
   logic recovery_prev_reg;

   assign int_event[IRQ_ALT_DONE] = active_link_test_done && alt_busy_reg;
   assign int_event[IRQ_REFL_DONE] = reflect_done;
   assign int_event[IRQ_RECOVERY] = recovery_enter && !recovery_prev_reg;
   assign int_status_next = int_event |
                            (int_status_reg & ~(wr_int_status ? wdata[NUM_IRQ-1:0] : '0));

   always_ff @(posedge clock) begin
      if (!rstn) begin
         int_status_reg <= '0;
         int_mask_reg <= '0;
         recovery_prev_reg <= 1'b0;
      end else begin
         int_status_reg <= int_status_next;
         recovery_prev_reg <= recovery_enter;
         if (wr_int_mask) begin
            int_mask_reg <= wdata[NUM_IRQ-1:0];
         end
      end
   end

   assign irq = |(int_status_reg & int_mask_reg);

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] store_rd;
   logic [DATA_W-1:0] alt_rd;
   logic [DATA_W-1:0] rdata_next;

   always_comb begin
      store_rd = '0;
      for (int k = 0; k < NUM_STORE; k++) begin
         if (rd_sel[k]) begin
            store_rd = store_reg[k];
         end
      end
   end

   always_comb begin
      alt_rd = '0;
      alt_rd[ALT_BUSY_BIT] = alt_busy_reg;
      alt_rd[ALT_SUM_LSB +: SUM_W] = alt_sum_reg;
      alt_rd[ALT_LOW_MSB:0] = alt_low_reg;
   end

   assign rdata_next = !rd ? '0 :
                       (|rd_sel) ? store_rd :
                       rd_alt ? alt_rd :
                       rd_int_status ? {{(DATA_W-NUM_IRQ){1'b0}}, int_status_reg} :
                       rd_int_mask ? {{(DATA_W-NUM_IRQ){1'b0}}, int_mask_reg} :
                       '0;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign rdata = rdata_reg;

   // ----------------------------------------------------------------
   // Gain training
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] glim;
   logic retrain_allow_reg;

   assign glim = store_reg[IDX_GLIM];

   gain_index_clamp u_gain (
      .clock(clock),
      .rstn(rstn),
      .start_index(store_reg[IDX_DSP3][START_GAIN_LSB +: GAIN_W]),
      .max_index(glim[MAX_GAIN_LSB +: GAIN_W]),
      .min_index(glim[MIN_GAIN_LSB +: GAIN_W]),
      .req_index(gain_req_index),
      .training_start(gain_training_start),
      .gain_index(gain_index)
   );

   always_ff @(posedge clock) begin
      if (!rstn) begin
         retrain_allow_reg <= 1'b0;
      end else begin
         retrain_allow_reg <= gain_retrain_req &&
                              !store_reg[IDX_RETRAIN][RETRAIN_DIS_BIT];
      end
   end

   assign gain_retrain_allow = retrain_allow_reg;

   // ----------------------------------------------------------------
   // Error monitor
   // ----------------------------------------------------------------
   mse_threshold_compare u_mse (
      .clock(clock),
      .rstn(rstn),
      .speed_100(speed_100),
      .mse_value(mse_value),
      .bad_threshold(store_reg[IDX_RECOV][MSE_W-1:0]),
      .good1_threshold(store_reg[IDX_TLOOP][MSE_W-1:0]),
      .good2_threshold(store_reg[IDX_LINKUP][MSE_W-1:0]),
      .recovery_enter(recovery_enter),
      .timing_converged(timing_converged),
      .linkup_ok(linkup_ok)
   );

   // ----------------------------------------------------------------
   // Training timers
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] tmr;

   assign tmr = store_reg[IDX_TIMERS];
   assign timer_state_shift = tmr[TMR_SHIFT_LSB +: TMR_SHIFT_W];
   assign timer_timing_loop = tmr[TMR_TLOOP_LSB +: TMR_TLOOP_W];
   assign timer_gain_a = tmr[TMR_GAIN_A_LSB +: TMR_GAIN_W];
   assign timer_gain_b = tmr[TMR_GAIN_B_LSB +: TMR_GAIN_W];

   // ----------------------------------------------------------------
   // Reflectometry settings
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] refl;
   logic [AVG_CODE_W-1:0] avg_code;

   assign refl = store_reg[IDX_REFL];
   assign avg_code = refl[AVG_LSB +: AVG_CODE_W];
   assign reflect_cross_enable = !refl[CROSS_DIS_BIT];
   assign reflect_run_transmit_pair = !refl[TX_BYPASS_BIT];
   assign reflect_run_receive_pair = !refl[RX_BYPASS_BIT];
   assign reflect_average_count = (avg_code == AVG_RESERVED) ? AVG_RESERVED_COUNT :
                                  (AVG_ONE << avg_code);
   assign reflect_pulse_level = store_reg[IDX_PULSE][PULSE_LSB +: PULSE_W];
endmodule
`default_nettype wire

// ---- verification/regs_checker_properties.sv ----
// Port checks for the DSP and cable diagnostic register bank.
// Assumes binding to phy_dsp_cable_diag_regs, one clock domain.
`default_nettype none
module regs_checker
   import phy_dsp_diag_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [DATA_W-1:0] rdata,
   // Engine side
   input wire logic gain_retrain_req,
   input wire logic gain_retrain_allow,
   input wire logic speed_100,
   input wire logic recovery_enter,
   input wire logic active_link_cable_test_start,
   input wire logic reflect_cross_enable,
   input wire logic reflect_run_transmit_pair,
   input wire logic reflect_run_receive_pair,
   input wire logic [AVG_W-1:0] reflect_average_count,
   input wire logic [PULSE_W-1:0] reflect_pulse_level
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   logic cfg_wr;
   assign cfg_wr = wr && addr == 9'h170;

   start_launch_a:
      assert property (wr && addr == ALT_OFFSET && wdata[15] |=> active_link_cable_test_start)
      else $error("start write gave no start pulse");
   start_cause_a:
      assert property (active_link_cable_test_start |->
         $past(wr && addr == ALT_OFFSET && wdata[15]))
      else $error("start pulse without a start write");
   cross_mode_a:
      assert property (cfg_wr |=> reflect_cross_enable == !$past(wdata[14]))
      else $error("cross enable wrong");
   tx_run_a:
      assert property (cfg_wr |=> reflect_run_transmit_pair == !$past(wdata[13]))
      else $error("transmit pair run wrong");
   rx_run_a:
      assert property (cfg_wr |=> reflect_run_receive_pair == !$past(wdata[12]))
      else $error("receive pair run wrong");
   avg_count_a:
      assert property (cfg_wr |=> reflect_average_count == (($past(wdata[10:8]) == 3'h7) ?
         7'h40 : 7'h01 << $past(wdata[10:8]))) else $error("average count wrong");
   pulse_level_a:
      assert property (wr && addr == 9'h171 |=> reflect_pulse_level == $past(wdata[3:0]))
      else $error("pulse level wrong");
   retrain_cause_a:
      assert property (gain_retrain_allow |-> $past(gain_retrain_req))
      else $error("retrain allowed without request");
   recovery_speed_a:
      assert property (recovery_enter |-> $past(speed_100))
      else $error("recovery outside 100M");
   rdata_idle_a:
      assert property (!$past(rd) |-> rdata == 16'h0000)
      else $error("read data outside read answer");
endmodule

bind phy_dsp_cable_diag_regs regs_checker u_regs_checker (.clock, .rstn, .addr, .wdata, .wr,
   .rd, .rdata, .gain_retrain_req, .gain_retrain_allow, .speed_100, .recovery_enter,
   .active_link_cable_test_start, .reflect_cross_enable, .reflect_run_transmit_pair,
   .reflect_run_receive_pair, .reflect_average_count, .reflect_pulse_level);
`default_nettype wire

// ---- verification/phy_dsp_cable_diag_regs_bench.sv ----
// Self-checking bench for the DSP and cable diagnostic register bank.
// Assumes the package constants; the port checker is bound separately.
`default_nettype none
module phy_dsp_cable_diag_regs_bench
   import phy_dsp_diag_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock, rstn, wr, rd, irq, gain_training_start, gain_retrain_req, gain_retrain_allow;
   logic speed_100, recovery_enter, timing_converged, linkup_ok, active_link_cable_test_start;
   logic active_link_test_done, reflect_cross_enable, reflect_run_transmit_pair;
   logic reflect_run_receive_pair, reflect_done, ts, rr, sp, rec;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata, v;
   logic [GAIN_W-1:0] gain_req_index, gain_index, q, g;
   logic [MSE_W-1:0] mse_value, m;
   logic [TMR_SHIFT_W-1:0] timer_state_shift;
   logic [TMR_TLOOP_W-1:0] timer_timing_loop;
   logic [TMR_GAIN_W-1:0] timer_gain_a, timer_gain_b;
   logic [SUM_W-1:0] active_link_test_sum, s;
   logic [AVG_W-1:0] reflect_average_count;
   logic [PULSE_W-1:0] reflect_pulse_level;
   logic [DATA_W-1:0] mreg [NUM_STORE];
   int num_errors, n_tests, i, d, seed;

   phy_dsp_cable_diag_regs u_phy_dsp_cable_diag_regs (.clock, .rstn, .addr, .wdata, .wr, .rd,
      .rdata, .irq, .gain_req_index, .gain_training_start, .gain_retrain_req, .gain_index,
      .gain_retrain_allow, .speed_100, .mse_value, .recovery_enter, .timing_converged,
      .linkup_ok, .timer_state_shift, .timer_timing_loop, .timer_gain_a, .timer_gain_b,
      .active_link_cable_test_start, .active_link_test_done, .active_link_test_sum,
      .reflect_cross_enable, .reflect_run_transmit_pair, .reflect_run_receive_pair,
      .reflect_average_count, .reflect_pulse_level, .reflect_done);

   // ----
   // Tasks
   // ----
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] dv);
      @(posedge clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= dv;
      @(posedge clock);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(posedge clock);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      check("rdata", rdata, exp);
   endtask
   task automatic alt_done(input logic [SUM_W-1:0] sv);
      @(posedge clock);
      active_link_test_done <= 1'b1;
      active_link_test_sum <= sv;
      @(posedge clock);
      active_link_test_done <= 1'b0;
      #1;
   endtask
   task automatic outs_chk;
      logic [15:0] r, t, o, e;
      r = mreg[IDX_REFL];
      t = mreg[IDX_TIMERS];
      o = {1'b0, timer_state_shift, timer_timing_loop, timer_gain_a, timer_gain_b};
      e = (r[10:8] == 3'h7) ? 16'h0040 : 16'h0001 << r[10:8];
      check("cross", 16'(reflect_cross_enable), 16'(!r[14]));
      check("run_tx", 16'(reflect_run_transmit_pair), 16'(!r[13]));
      check("run_rx", 16'(reflect_run_receive_pair), 16'(!r[12]));
      check("avg", 16'(reflect_average_count), e);
      check("pulse", 16'(reflect_pulse_level), 16'(mreg[IDX_PULSE][3:0]));
      check("timers", o, {1'b0, t[14:0]});
   endtask
   task automatic final_report;
      if (num_errors == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   always #25 clock = ~clock;
   initial begin
      #2000000;
      num_errors++;
      final_report();
   end

   // ----
   // Main sequence
   // ----
   initial begin
      clock = 1'b0;
      rstn = 1'b0;
      {wr, rd, gain_training_start, gain_retrain_req, speed_100, reflect_done} = '0;
      {addr, wdata, gain_req_index, mse_value, active_link_test_done, active_link_test_sum} = '0;
      num_errors = 0;
      n_tests = 0;
      seed = $urandom(32'h1DD42C4B);
      repeat (6) @(posedge clock);
      rstn <= 1'b1;
      for (i = 0; i < NUM_STORE; i++) begin
         mreg[i] = STORE_RESET[i];
         rd_chk(STORE_OFFSET[i], mreg[i]);
      end
      outs_chk();
      rd_chk(ALT_OFFSET, 16'h0001);
      reg_write(9'h100, 16'hFFFF);
      rd_chk(9'h100, 16'h0000);
      for (i = 0; i < NUM_STORE; i++) begin
         v = 16'($urandom);
         mreg[i] = v & STORE_WMASK[i];
         reg_write(STORE_OFFSET[i], v);
      end
      for (i = 0; i < NUM_STORE; i++) rd_chk(STORE_OFFSET[i], mreg[i]);
      for (i = 0; i < 8; i++) begin
         v = 16'($urandom) & STORE_WMASK[IDX_REFL];
         v[10:8] = 3'(i);
         mreg[IDX_REFL] = v;
         reg_write(STORE_OFFSET[IDX_REFL], v);
         outs_chk();
      end
      // Active-link test with idle done, zero start and real run
      reg_write(INT_MASK_OFFSET, 16'h0000);
      reg_write(INT_STATUS_OFFSET, 16'h0007);
      reg_write(ALT_OFFSET, 16'h7FF5);
      check("start", 16'(active_link_cable_test_start), 16'h0000);
      alt_done(8'hA5);
      rd_chk(ALT_OFFSET, 16'h0005);
      rd_chk(INT_STATUS_OFFSET, 16'h0000);
      reg_write(ALT_OFFSET, 16'h8005);
      check("start", 16'(active_link_cable_test_start), 16'h0001);
      @(posedge clock);
      #1;
      check("start", 16'(active_link_cable_test_start), 16'h0000);
      rd_chk(ALT_OFFSET, 16'h1005);
      s = 8'($urandom);
      alt_done(s);
      rd_chk(ALT_OFFSET, {4'h0, s, 4'h5});
      rd_chk(INT_STATUS_OFFSET, 16'h0001);
      check("irq", 16'(irq), 16'h0000);
      // Interrupt raised, cleared
      reg_write(INT_MASK_OFFSET, 16'h0002);
      @(posedge clock);
      reflect_done <= 1'b1;
      @(posedge clock);
      reflect_done <= 1'b0;
      #1;
      check("irq", 16'(irq), 16'h0001);
      rd_chk(INT_STATUS_OFFSET, 16'h0003);
      reg_write(INT_STATUS_OFFSET, 16'h0003);
      check("irq", 16'(irq), 16'h0000);
      // Gain clamp, retrain and error thresholds
      mreg[IDX_GLIM] = 16'h00A3;
      reg_write(STORE_OFFSET[IDX_GLIM], mreg[IDX_GLIM]);
      reg_write(STORE_OFFSET[IDX_DSP3], 16'h6005);
      rec = 1'b0;
      for (d = 0; d < 2; d++) begin
         mreg[IDX_RETRAIN][11] = d[0];
         reg_write(STORE_OFFSET[IDX_RETRAIN], mreg[IDX_RETRAIN]);
         for (i = 0; i < 80; i++) begin
            q = 4'($urandom);
            ts = ($urandom_range(3) == 0);
            rr = 1'($urandom);
            m = 15'($urandom);
            sp = 1'($urandom);
            @(posedge clock);
            gain_req_index <= q;
            gain_training_start <= ts;
            gain_retrain_req <= rr;
            mse_value <= m;
            speed_100 <= sp;
            @(posedge clock);
            #1;
            g = ts ? 4'h5 : (q > 4'hA) ? 4'hA : (q < 4'h3) ? 4'h3 : q;
            check("gain", 16'(gain_index), 16'(g));
            check("retrain", 16'(gain_retrain_allow), 16'(rr && !d[0]));
            check("recovery", 16'(recovery_enter), 16'(sp && m > mreg[IDX_RECOV][14:0]));
            check("converged", 16'(timing_converged), 16'(sp && m < mreg[IDX_TLOOP][14:0]));
            check("linkup", 16'(linkup_ok), 16'(sp && m < mreg[IDX_LINKUP][14:0]));
            rec = rec | (sp && m > mreg[IDX_RECOV][14:0]);
         end
      end
      rd_chk(INT_STATUS_OFFSET, {13'h0000, rec, 2'h0});
      final_report();
   end
endmodule
`default_nettype wire
